// *** design/host_bus_consts.svh ***
//------------------------------------------------------------
// Behaviour
//------------------------------------------------------------
`ifndef HOST_BUS_CONSTS_SVH
`define HOST_BUS_CONSTS_SVH

//------------------------------------------------------------
// Timing
//------------------------------------------------------------
`define MCLK_MHZ          50
`define CPU_RESET_HOLD_US 1000
`define RST_CNT_W         16
`define SNOOP_OFFSET      3'h4
`define SNOOP_LAST        3'h1
`define PHASE_ZERO        3'h0

//------------------------------------------------------------
// Bus layout and response codes
//------------------------------------------------------------
`define HA_MSB      31
`define HA_LSB      3
`define HD_W        64
`define REQ_W       5
`define RS_W        3
`define STRAP_BIT   15
`define BEAT_LAST   2'h3
`define BEAT_ZERO   2'h0
`define RS_IDLE     3'h0
`define RS_RETRY    3'h1
`define RS_DEFER    3'h2
`define RS_RSVD     3'h3
`define RS_HARDFAIL 3'h4
`define RS_NODATA   3'h5
`define RS_IWB      3'h6
`define RS_NORMAL   3'h7

`endif

// *** design/host_bus_pkg.sv ***
`include "host_bus_consts.svh"
package host_bus_pkg;
  //----------------------------------------------------------
  // State types
  //----------------------------------------------------------
  typedef enum logic [5:0] {
    SN_IDLE = 6'h01,
    SN_PRIO = 6'h02,
    SN_REQA = 6'h04,
    SN_REQB = 6'h08,
    SN_WAIT = 6'h10,
    SN_DONE = 6'h20
  } snoop_state_t;
  typedef enum logic [4:0] {
    RP_IDLE  = 5'h01,
    RP_TRDY  = 5'h02,
    RP_WDATA = 5'h04,
    RP_RESP  = 5'h08,
    RP_RDATA = 5'h10
  } resp_state_t;
  typedef logic [`RS_W-1:0] resp_code_t;
endpackage

// *** design/cpu_reset_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface cpu_reset_if;
  logic southbridgeActive;
  logic hubResetReq;
  logic cpuResetActive;
  modport gen (input southbridgeActive, input hubResetReq, output cpuResetActive);
  modport ctl (output southbridgeActive, output hubResetReq, input cpuResetActive);
endinterface
`default_nettype wire

// *** design/cpu_reset_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpu_reset_gen
  import host_bus_pkg::*;
#(
  parameter int HOLD_CYCLES = `CPU_RESET_HOLD_US * `MCLK_MHZ
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  cpu_reset_if.gen  rstIf
);
  localparam logic [`RST_CNT_W-1:0] HOLD_LOAD = `RST_CNT_W'(HOLD_CYCLES - 1);

  logic [`RST_CNT_W-1:0] holdCnt;
  logic                  active;

  // Reload on either source; counting keeps the output asserted
  wire loadHold = rstIf.southbridgeActive | rstIf.hubResetReq;
  wire counting = holdCnt != {`RST_CNT_W{1'b0}};

  // Hold timer; a new request restarts the full hold time
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      holdCnt <= {`RST_CNT_W{1'b0}};
      active  <= 1'b1;
    end else if (loadHold) begin
      holdCnt <= HOLD_LOAD;
      active  <= 1'b1;
    end else if (counting) begin
      holdCnt <= holdCnt - 1'b1;
    end else begin
      active  <= 1'b0;
    end
  end

  assign rstIf.cpuResetActive = active;
endmodule // cpu_reset_gen
`default_nettype wire

// *** design/host_bus_agent.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_bus_agent
  import host_bus_pkg::*;
#(
  parameter int RESET_HOLD_CYCLES = `CPU_RESET_HOLD_US * `MCLK_MHZ
) (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic                     southbridgeReset_n,
  input  wire logic                     hubResetReq,
  input  wire logic                     stopClockGrantedHalt,
  output var  logic                     processorResetOut_n,
  input  wire logic [`HA_MSB:`HA_LSB]   hostAddrIn_n,
  output var  logic [`HA_MSB:`HA_LSB]   hostAddrOut_n,
  output var  logic                     hostAddrOe_n,
  input  wire logic [`HD_W-1:0]         hostDataIn_n,
  output var  logic [`HD_W-1:0]         hostDataOut_n,
  output var  logic                     hostDataOe_n,
  input  wire logic                     addressStrobeIn_n,
  output var  logic                     addressStrobeOut_n,
  output var  logic                     addressStrobeOe_n,
  input  wire logic [`REQ_W-1:0]        requestCmdIn_n,
  output var  logic [`REQ_W-1:0]        requestCmdOut_n,
  output var  logic                     requestCmdOe_n,
  input  wire logic                     blockNextRequestIn_n,
  output var  logic                     blockNextRequestOut_n,
  output var  logic                     blockNextRequestOe_n,
  output var  logic                     priorityBusRequest_n,
  input  wire logic                     dataBusBusyIn_n,
  output var  logic                     dataBusBusyOut_n,
  output var  logic                     dataBusBusyOe_n,
  input  wire logic                     dataReadyIn_n,
  output var  logic                     dataReadyOut_n,
  output var  logic                     dataReadyOe_n,
  input  wire logic                     snoopHitIn_n,
  output var  logic                     snoopHitOut_n,
  output var  logic                     snoopHitOe_n,
  input  wire logic                     snoopModHitIn_n,
  output var  logic                     snoopModHitOut_n,
  output var  logic                     snoopModHitOe_n,
  output var  logic                     deferOut_n,
  input  wire logic                     hostBusLock_n,
  output var  logic                     targetReadyOut_n,
  output var  logic                     targetReadyOe_n,
  output var  logic [`RS_W-1:0]         responseCodeOut_n,
  output var  logic                     responseCodeOe_n,
  input  wire logic                     throttleRequests,
  input  wire logic                     snoopStallReq,
  input  wire logic                     deferThis,
  input  wire logic                     retryThis,
  output var  logic                     reqValid,
  output var  logic [`HA_MSB:`HA_LSB]   reqAddr,
  output var  logic [`REQ_W-1:0]        reqCmdFirst,
  output var  logic [`REQ_W-1:0]        reqCmdSecond,
  output var  logic                     reqLocked,
  input  wire logic                     respValid,
  input  wire logic [`RS_W-1:0]         respCode,
  input  wire logic                     respWrite,
  input  wire logic [`HD_W-1:0]         respData,
  output var  logic                     respReady,
  output var  logic                     dataTake,
  output var  logic [`HD_W-1:0]         writeData,
  output var  logic                     writeDataValid,
  input  wire logic                     pciSnoopReq,
  input  wire logic [`HA_MSB:`HA_LSB]   pciSnoopAddr,
  input  wire logic [`REQ_W-1:0]        pciSnoopCmdFirst,
  input  wire logic [`REQ_W-1:0]        pciSnoopCmdSecond,
  output var  logic                     pciSnoopDone,
  output var  logic                     pciSnoopHit,
  output var  logic                     pciSnoopModified,
  output var  logic                     atomicHold
);
  //----------------------------------------------------------
  // Processor reset and strap
  //----------------------------------------------------------
  cpu_reset_if rstIf ();

  assign rstIf.southbridgeActive = ~southbridgeReset_n;
  assign rstIf.hubResetReq       = hubResetReq;

  cpu_reset_gen #(
    .HOLD_CYCLES (RESET_HOLD_CYCLES)
  ) u_cpu_reset_gen (
    .mclk  (mclk),
    .rst_n (rst_n),
    .rstIf (rstIf)
  );

  logic strapLevel;
  logic strapTail;

  // Strap is sampled while reset is held, never under the block reset itself
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strapLevel <= 1'b0;
      strapTail  <= 1'b1;
    end else begin
      if (rstIf.cpuResetActive) begin
        strapLevel <= stopClockGrantedHalt;
      end
      strapTail <= rstIf.cpuResetActive;
    end
  end

  // Strap stays on the pin one cycle past the reset rise for hold time
  wire strapDrive = rstIf.cpuResetActive | strapTail | ~processorResetOut_n;

  //----------------------------------------------------------
  // Processor request capture
  //----------------------------------------------------------
  wire procAds = ~addressStrobeIn_n & addressStrobeOe_n;
  wire lockIn  = ~hostBusLock_n;

  logic       adsSeen;
  logic [2:0] procPhase;
  logic       deferDecision;
  logic       lockActive;

  // Two-clock request phase: first clock address and type, second the rest
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      adsSeen      <= 1'b0;
      reqValid     <= 1'b0;
      reqAddr      <= {(`HA_MSB-`HA_LSB+1){1'b0}};
      reqCmdFirst  <= {`REQ_W{1'b0}};
      reqCmdSecond <= {`REQ_W{1'b0}};
      reqLocked    <= 1'b0;
    end else begin
      adsSeen  <= procAds;
      reqValid <= adsSeen;
      if (procAds) begin
        reqAddr     <= ~hostAddrIn_n;
        reqCmdFirst <= ~requestCmdIn_n;
        reqLocked   <= lockIn;
      end
      if (adsSeen) begin
        reqCmdSecond <= ~requestCmdIn_n;
      end
    end
  end

  // Snoop-phase timer; a new strobe inside the window restarts it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      procPhase     <= `PHASE_ZERO;
      deferDecision <= 1'b0;
    end else begin
      if (procAds) begin
        procPhase <= `SNOOP_OFFSET;
      end else if (procPhase != `PHASE_ZERO) begin
        procPhase <= procPhase - 1'b1;
      end
      if (reqValid) begin
        deferDecision <= deferThis | retryThis;
      end
    end
  end

  wire procSnoopSlot = procPhase == `SNOOP_LAST;

  // Lock window; the negation seen in the same cycle wins over the set
  wire next_lockActive = (procAds & lockIn) | (lockActive & lockIn);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lockActive <= 1'b0;
      atomicHold <= 1'b0;
    end else begin
      lockActive <= next_lockActive;
      atomicHold <= next_lockActive;
    end
  end

  //----------------------------------------------------------
  // Snoop issue on behalf of the PCI side
  //----------------------------------------------------------
  snoop_state_t snState;
  snoop_state_t next_snState;
  logic [2:0]   snWait;

  // Only start when the processor is neither locked nor blocking requests
  wire busClear = ~lockActive & ~procAds & ~adsSeen & ~blockNextRequestIn_n == 1'b0;
  wire snStart  = busClear & ~lockActive & blockNextRequestIn_n;
  wire snSample = snWait == `PHASE_ZERO;
  wire snStall  = ~snoopHitIn_n & ~snoopModHitIn_n;

  always_comb begin
    next_snState = snState;
    unique case (snState)
      SN_IDLE: if (pciSnoopReq && !rstIf.cpuResetActive) next_snState = SN_PRIO;
      SN_PRIO: if (snStart) next_snState = SN_REQA;
      SN_REQA: next_snState = SN_REQB;
      SN_REQB: next_snState = SN_WAIT;
      SN_WAIT: if (snSample && !snStall) next_snState = SN_DONE;
      SN_DONE: next_snState = SN_IDLE;
    endcase
  end

  // Window timer reloads on a stall so the window is pushed out
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      snState <= SN_IDLE;
      snWait  <= `PHASE_ZERO;
    end else begin
      snState <= next_snState;
      if (next_snState == SN_REQB || (snState == SN_WAIT && snSample)) begin
        snWait <= `SNOOP_OFFSET - 1'b1;
      end else if (!snSample) begin
        snWait <= snWait - 1'b1;
      end
    end
  end

  // Results: hit alone is a clean copy, modified hit means writeback follows
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pciSnoopDone     <= 1'b0;
      pciSnoopHit      <= 1'b0;
      pciSnoopModified <= 1'b0;
    end else begin
      pciSnoopDone <= next_snState == SN_DONE;
      if (snState == SN_WAIT && snSample && !snStall) begin
        pciSnoopHit      <= ~snoopHitIn_n;
        pciSnoopModified <= ~snoopModHitIn_n;
      end
    end
  end

  //----------------------------------------------------------
  // Response and data phases for processor cycles
  //----------------------------------------------------------
  resp_state_t rpState;
  resp_state_t next_rpState;
  resp_code_t  rpCode;
  logic [1:0]  beatCnt;

  // Reserved and hard-failure codes are never put on the bus
  wire        codeIllegal = respCode == `RS_RSVD || respCode == `RS_HARDFAIL;
  wire [2:0]  codeLegal   = codeIllegal ? `RS_NODATA : respCode;
  wire        codeData    = codeLegal == `RS_NORMAL || codeLegal == `RS_IWB;
  wire        procDrdy    = ~dataReadyIn_n & dataReadyOe_n;
  wire        lastWrBeat  = procDrdy & dataBusBusyIn_n;
  wire        lastRdBeat  = beatCnt == `BEAT_LAST;

  always_comb begin
    next_rpState = rpState;
    unique case (rpState)
      RP_IDLE:  if (respValid) next_rpState = respWrite ? RP_TRDY : (codeData ? RP_RDATA : RP_RESP);
      RP_TRDY:  next_rpState = RP_WDATA;
      RP_WDATA: if (lastWrBeat) next_rpState = RP_RESP;
      RP_RESP:  next_rpState = RP_IDLE;
      RP_RDATA: if (lastRdBeat) next_rpState = RP_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rpState <= RP_IDLE;
      rpCode  <= `RS_IDLE;
      beatCnt <= `BEAT_ZERO;
    end else begin
      rpState <= next_rpState;
      if (rpState == RP_IDLE && respValid) begin
        rpCode <= respWrite ? `RS_NODATA : codeLegal;
      end
      beatCnt <= (next_rpState == RP_RDATA && rpState == RP_RDATA) ? beatCnt + 1'b1 : `BEAT_ZERO;
    end
  end

  // Write data from the processor is taken on each of its data-ready clocks
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      writeData      <= {`HD_W{1'b0}};
      writeDataValid <= 1'b0;
    end else begin
      writeDataValid <= rpState == RP_WDATA && procDrdy;
      if (rpState == RP_WDATA && procDrdy) begin
        writeData <= ~hostDataIn_n;
      end
    end
  end

  //----------------------------------------------------------
  // Pin drive decode
  //----------------------------------------------------------
  wire nReqA    = next_snState == SN_REQA;
  wire nReqB    = next_snState == SN_REQB;
  wire nPrio    = next_snState == SN_PRIO || nReqA || nReqB;
  wire nRdBeat  = next_rpState == RP_RDATA;
  wire nRdFirst = nRdBeat && rpState != RP_RDATA;
  wire nRdLast  = nRdBeat && rpState == RP_RDATA && beatCnt == `BEAT_LAST - 1'b1;
  wire nResp    = (next_rpState == RP_RESP) || nRdFirst;
  wire nHitDrv  = procSnoopSlot & snoopStallReq;
  wire [`RS_W-1:0] nCode = (rpState == RP_IDLE) ? codeLegal : rpCode;

  // Address lines: strap in reset, snoop address in request, else released
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      processorResetOut_n <= 1'b0;
      hostAddrOut_n       <= {(`HA_MSB-`HA_LSB+1){1'b1}};
      hostAddrOe_n        <= 1'b1;
    end else begin
      processorResetOut_n <= ~rstIf.cpuResetActive;
      hostAddrOe_n        <= ~(nReqA | nReqB | strapDrive);
      if (nReqA || nReqB) begin
        hostAddrOut_n <= ~pciSnoopAddr;
      end else begin
        hostAddrOut_n             <= {(`HA_MSB-`HA_LSB+1){1'b1}};
        hostAddrOut_n[`STRAP_BIT] <= strapDrive ? strapLevel : 1'b1;
      end
    end
  end

  // Request phase pins: strobe in the first clock only, command in both
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addressStrobeOut_n    <= 1'b1;
      addressStrobeOe_n     <= 1'b1;
      requestCmdOut_n       <= {`REQ_W{1'b1}};
      requestCmdOe_n        <= 1'b1;
      priorityBusRequest_n  <= 1'b1;
      blockNextRequestOut_n <= 1'b1;
      blockNextRequestOe_n  <= 1'b1;
    end else begin
      addressStrobeOut_n    <= ~nReqA;
      addressStrobeOe_n     <= ~(nReqA | nReqB);
      requestCmdOut_n       <= nReqA ? ~pciSnoopCmdFirst : ~pciSnoopCmdSecond;
      requestCmdOe_n        <= ~(nReqA | nReqB);
      priorityBusRequest_n  <= ~nPrio;
      blockNextRequestOut_n <= 1'b0;
      blockNextRequestOe_n  <= ~throttleRequests;
    end
  end

  // Snoop phase, response and data pins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      deferOut_n        <= 1'b1;
      snoopHitOut_n     <= 1'b1;
      snoopHitOe_n      <= 1'b1;
      snoopModHitOut_n  <= 1'b1;
      snoopModHitOe_n   <= 1'b1;
      targetReadyOut_n  <= 1'b1;
      targetReadyOe_n   <= 1'b1;
      responseCodeOut_n <= {`RS_W{1'b1}};
      responseCodeOe_n  <= 1'b1;
      dataBusBusyOut_n  <= 1'b1;
      dataBusBusyOe_n   <= 1'b1;
      dataReadyOut_n    <= 1'b1;
      dataReadyOe_n     <= 1'b1;
      hostDataOut_n     <= {`HD_W{1'b1}};
      hostDataOe_n      <= 1'b1;
      dataTake          <= 1'b0;
      respReady         <= 1'b0;
    end else begin
      deferOut_n        <= ~(procSnoopSlot & deferDecision);
      snoopHitOut_n     <= ~nHitDrv;
      snoopHitOe_n      <= ~nHitDrv;
      snoopModHitOut_n  <= ~nHitDrv;
      snoopModHitOe_n   <= ~nHitDrv;
      targetReadyOut_n  <= ~(next_rpState == RP_TRDY);
      targetReadyOe_n   <= ~(next_rpState == RP_TRDY);
      responseCodeOut_n <= nResp ? ~nCode : {`RS_W{1'b1}};
      responseCodeOe_n  <= ~nResp;
      dataBusBusyOut_n  <= ~(nRdBeat & ~nRdLast);
      dataBusBusyOe_n   <= ~nRdBeat;
      dataReadyOut_n    <= ~nRdBeat;
      dataReadyOe_n     <= ~nRdBeat;
      hostDataOut_n     <= ~respData;
      hostDataOe_n      <= ~nRdBeat;
      dataTake          <= nRdBeat;
      respReady         <= next_rpState == RP_IDLE;
    end
  end

  //----------------------------------------------------------
  // Checks
  //----------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_ownStrobe;
    !addressStrobeOe_n && !addressStrobeOut_n;
  endsequence
  sequence s_secondClock;
    addressStrobeOut_n && !requestCmdOe_n && !addressStrobeOe_n;
  endsequence

  AST_RESET_FOLLOWS: assert property (!southbridgeReset_n |-> ##2 !processorResetOut_n)
    else $error("processor reset not following system reset");
  AST_HUB_PULSE: assert property (hubResetReq |-> ##2 !processorResetOut_n [*8])
    else $error("hub reset pulse too short");
  AST_STRAP_AT_RISE: assert property ($rose(processorResetOut_n) |->
      !hostAddrOe_n && hostAddrOut_n[`STRAP_BIT] == strapLevel)
    else $error("strap not on address bit at reset rise");
  AST_ADDR_INPUT: assert property (procAds |-> hostAddrOe_n)
    else $error("address driven during processor cycle");
  AST_ADDR_INVERT: assert property (reqValid |-> reqAddr == ~$past(hostAddrIn_n, 2))
    else $error("captured address not inverted");
  AST_STROBE_ONCE: assert property (s_ownStrobe |=> s_secondClock)
    else $error("strobe or command wrong in second request clock");
  AST_BLOCK_NEXT: assert property (throttleRequests |=> !blockNextRequestOe_n)
    else $error("block next request not driven");
  AST_PRIO_FIRST: assert property (s_ownStrobe |-> !priorityBusRequest_n && $past(!priorityBusRequest_n)
      && !$past(lockActive))
    else $error("snoop request without priority ownership");
  AST_BUSY_BURST: assert property (nRdFirst |=> !dataBusBusyOut_n [*3] ##1 dataBusBusyOut_n && !dataReadyOut_n)
    else $error("data busy not held across burst");
  AST_DEFER_SLOT: assert property (!deferOut_n |-> $past(procPhase) == `SNOOP_LAST && $past(deferDecision))
    else $error("defer outside snoop slot");
  AST_DATA_READY_STROBE_DATA: assert property (!dataReadyOe_n |-> !dataReadyOut_n && !hostDataOe_n)
    else $error("data ready without data");
  AST_STALL_HOLD: assert property (snState == SN_WAIT && snSample && snStall |=> snState == SN_WAIT)
    else $error("stall did not extend window");
  AST_TRDY_WRITE: assert property (!targetReadyOe_n |-> rpState == RP_TRDY ##1 rpState == RP_WDATA)
    else $error("target ready outside write data entry");
  AST_CODE_LEGAL: assert property (!responseCodeOe_n |->
      ~responseCodeOut_n != `RS_RSVD && ~responseCodeOut_n != `RS_HARDFAIL)
    else $error("reserved response code driven");
endmodule // host_bus_agent
`default_nettype wire

// *** tb/cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------
// Processor stand-in on the shared host bus
// -------------------------------------------
module cpu_model (
  input  wire logic        mclk,
  input  wire logic        go,
  input  wire logic        rstOut_n,
  input  wire logic        bnr_n,
  input  wire logic        priority_bus_request_n,
  input  wire logic        adsPin_n,
  input  wire logic [31:3] addr,
  input  wire logic [9:0]  cmd,
  input  wire logic [1:0]  ans,
  output logic             ads_n,
  output logic [31:3]      addr_n,
  output logic [4:0]       cmd_n,
  output logic             hit_n,
  output logic             snoop_modified_hit_n
);
  int sn = 0;
  initial {ads_n, addr_n, cmd_n} = '1;
  // One request per go; waits out reset, blocking and the priority agent
  initial forever begin
    @(posedge mclk iff go);
    while (!(rstOut_n && bnr_n && priority_bus_request_n)) @(posedge mclk);
    #1 ads_n = 1'b0;
    addr_n = ~addr;
    cmd_n = ~cmd[9:5];
    @(posedge mclk) #1 ads_n = 1'b1;
    cmd_n = ~cmd[4:0];
    // Released lines float to the pull-up level
    @(posedge mclk) #1 addr_n = '1;
    cmd_n = '1;
  end
  // Snoop answer window opens on the hub's own strobe; answer 3 asserts both hit lines, a stall
  always @(posedge mclk) sn <= (!adsPin_n && ads_n) ? 1 : (sn != 0 && sn < 8) ? sn + 1 : 0;
  assign hit_n = !(sn != 0 && ans[0]);
  assign snoop_modified_hit_n = !(sn != 0 && ans[1]);
endmodule // cpu_model
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import host_bus_pkg::*;
  localparam int HOLD = 20;
  logic mclk, rst_n, southbridgeReset_n, hubResetReq, stopClockGrantedHalt, processorResetOut_n, hostAddrOe_n;
  logic hostDataOe_n, addressStrobeOut_n, addressStrobeOe_n, requestCmdOe_n, blockNextRequestOut_n;
  logic blockNextRequestOe_n, priorityBusRequest_n, dataBusBusyIn_n, dataBusBusyOut_n, dataBusBusyOe_n;
  logic dataReadyIn_n, dataReadyOut_n, dataReadyOe_n, snoopHitOut_n, snoopHitOe_n, snoopModHitOut_n;
  logic snoopModHitOe_n, deferOut_n, hostBusLock_n, targetReadyOut_n, targetReadyOe_n, responseCodeOe_n;
  logic throttleRequests, snoopStallReq, deferThis, retryThis, reqValid, reqLocked, respValid, respWrite;
  logic respReady, dataTake, writeDataValid, pciSnoopReq, pciSnoopDone, pciSnoopHit, pciSnoopModified;
  logic atomicHold, go, cpuAds_n, cpuHit_n, cpuHitm_n;
  logic [1:0] ans;
  logic [2:0] respCode, responseCodeOut_n;
  logic [4:0] requestCmdOut_n, reqCmdFirst, reqCmdSecond, pciSnoopCmdFirst, pciSnoopCmdSecond, cpuCmd_n;
  logic [9:0] cmd;
  logic [31:3] hostAddrOut_n, reqAddr, pciSnoopAddr, cpuAddr_n, addr, seenAddr;
  logic [63:0] hostDataIn_n, hostDataOut_n, respData, writeData;
  wire logic addressStrobeIn_n, blockNextRequestIn_n, snoopHitIn_n, snoopModHitIn_n;
  wire logic [4:0] requestCmdIn_n;
  wire logic [31:3] hostAddrIn_n;
  int badCount = 0, comparisons = 0, n, s;
  // Open-drain pins: low wins, released lines sit high
  assign addressStrobeIn_n = cpuAds_n & (addressStrobeOe_n | addressStrobeOut_n);
  assign hostAddrIn_n = cpuAddr_n & (hostAddrOut_n | {29{hostAddrOe_n}});
  assign requestCmdIn_n = cpuCmd_n & (requestCmdOut_n | {5{requestCmdOe_n}});
  assign snoopHitIn_n = cpuHit_n & (snoopHitOe_n | snoopHitOut_n);
  assign snoopModHitIn_n = cpuHitm_n & (snoopModHitOe_n | snoopModHitOut_n);
  assign blockNextRequestIn_n = blockNextRequestOe_n | blockNextRequestOut_n;
  host_bus_agent #(.RESET_HOLD_CYCLES(HOLD)) i_host_bus_agent (.*);
  cpu_model i_cpu_model (.mclk, .go, .rstOut_n(processorResetOut_n), .bnr_n(blockNextRequestIn_n),
    .priority_bus_request_n(priorityBusRequest_n), .adsPin_n(addressStrobeIn_n), .addr, .cmd, .ans, .ads_n(cpuAds_n),
    .addr_n(cpuAddr_n), .cmd_n(cpuCmd_n), .hit_n(cpuHit_n), .snoop_modified_hit_n(cpuHitm_n));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Comparison, verdict and bounded waits
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic guard(int k);
    if (k >= 99) begin
      badCount++;
      conclude();
    end
  endtask
  task automatic waitRise(output int k);
    k = 0;
    while (processorResetOut_n !== 1'b1 && k < 99) @(posedge mclk) #1 k++;
    guard(k);
    check("strap", hostAddrOut_n[15], stopClockGrantedHalt);
    check("strapOe", hostAddrOe_n, 0);
  endtask
  function automatic logic inHold(int k); return k >= HOLD - 2 && k <= HOLD + 3; endfunction
  function automatic logic [2:0] expCode(int c); return (c == 3 || c == 4) ? 3'h5 : 3'(c); endfunction
  initial begin
    void'($urandom(32'h5bee));
    {rst_n, southbridgeReset_n, hubResetReq, go, respValid, respWrite, pciSnoopReq, throttleRequests} = '0;
    {snoopStallReq, deferThis, retryThis, respCode, respData, hostDataIn_n, cmd, addr, ans} = '0;
    {pciSnoopAddr, pciSnoopCmdFirst, pciSnoopCmdSecond} = '0;
    {dataBusBusyIn_n, dataReadyIn_n, hostBusLock_n} = '1;
    stopClockGrantedHalt = 1'($urandom);
    repeat (8) @(posedge mclk);
    #1 check("rst", processorResetOut_n, 0);
    rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1 southbridgeReset_n = 1'b1;
    waitRise(n);
    check("hold", inHold(n), 1);
    stopClockGrantedHalt = ~stopClockGrantedHalt;
    hubResetReq = 1'b1;
    @(posedge mclk) #1 hubResetReq = 1'b0;
    @(posedge mclk);
    @(posedge mclk) #1 check("hub", processorResetOut_n, 0);
    waitRise(n);
    check("pulse", inHold(n), 1);
    repeat (3) @(posedge mclk);
    // Processor requests with random defer and retry choices
    for (int i = 0; i < 6; i++) begin
      addr = 29'($urandom);
      cmd = 10'($urandom);
      {deferThis, retryThis} = 2'($urandom);
      hostDataIn_n = {$urandom, $urandom};
      #1 go = 1'b1;
      hostBusLock_n = (i != 5);
      @(posedge mclk) #1 go = 1'b0;
      n = 0;
      while (!reqValid && n < 99) @(posedge mclk) #1 n++;
      guard(n);
      check("addr", reqAddr, addr);
      check("cmdA", reqCmdFirst, cmd[9:5]);
      check("cmdB", reqCmdSecond, cmd[4:0]);
      check("lock", reqLocked, i == 5);
      check("atomic", atomicHold, i == 5);
      repeat (3) @(posedge mclk);
      #1 check("defer", deferOut_n, !(deferThis || retryThis));
      repeat (4) @(posedge mclk);
    end
    hostBusLock_n = 1'b1;
    // Response codes 1 to 7, reserved ones included
    for (int i = 1; i < 8; i++) begin
      #1 respCode = 3'(i);
      respData = {$urandom, $urandom};
      {throttleRequests, snoopStallReq} = 2'($urandom);
      respValid = 1'b1;
      n = 0;
      while (!respReady && n < 99) @(posedge mclk) #1 n++;
      guard(n);
      @(posedge mclk) #1 respValid = 1'b0;
      check("rs", {~responseCodeOut_n}, expCode(i));
      if (i >= 6) begin
        check("data_ready_strobe", dataReadyOut_n, 0);
        check("data_bus_busy", dataBusBusyOut_n, 0);
        check("data", hostDataOut_n, ~respData);
      end
      repeat (8) @(posedge mclk);
    end
    // Write: target ready, one processor data beat, then no-data response
    #1 {respWrite, respValid, hostDataIn_n} = {2'b11, $urandom, $urandom};
    @(posedge mclk) #1 respValid = 1'b0;
    check("trdy", targetReadyOut_n, 0);
    @(posedge mclk) #1 {dataReadyIn_n, dataBusBusyIn_n} = 2'b01;
    @(posedge mclk) #1 dataReadyIn_n = 1'b1;
    check("wdat", writeData, ~hostDataIn_n);
    check("wval", writeDataValid, 1);
    check("wrs", {~responseCodeOut_n}, 3'h5);
    respWrite = 1'b0;
    repeat (4) @(posedge mclk);
    // Snoops on behalf of the PCI side: miss, clean hit, modified hit, stall
    {throttleRequests, snoopStallReq} = '0;
    for (int k = 0; k < 4; k++) begin
      ans = 2'(k);
      pciSnoopAddr = 29'($urandom);
      {pciSnoopCmdFirst, pciSnoopCmdSecond} = 10'($urandom);
      #1 pciSnoopReq = 1'b1;
      {n, s} = '0;
      while (!pciSnoopDone && n < 99) begin
        @(posedge mclk) #1 n++;
        if (!addressStrobeOe_n && !addressStrobeOut_n) s++;
        if (!addressStrobeOe_n && !addressStrobeOut_n) seenAddr = hostAddrOut_n;
      end
      guard(n);
      pciSnoopReq = 1'b0;
      check("strobe", s, 1);
      check("snpAddr", seenAddr, {~pciSnoopAddr});
      check("mod", pciSnoopModified, k < 3 && ans[1]);
      if (!ans[1] || k == 3) check("hit", pciSnoopHit, k < 3 && ans[0]);
      repeat (6) @(posedge mclk);
    end
    conclude();
  end
endmodule // testbench
`default_nettype wire
